// >>> logic/pch_pkg.sv
// shared constants for the configuration header tail block
// Functional notes
// RQ1: rom window base writable in upper bits; bits 16 to 1 read zero.
// RQ2: rom decode only when rom enable bit and memory space enable are both set.
// RQ3: capability pointer at 34h reads fixed C0h; upper bits reserved zero.
// RQ4: max latency byte bits 31-24, read-only, loaded from eeprom at reset.
// RQ5: min grant byte bits 23-16, read-only, loaded from eeprom at reset.
// RQ6: interrupt pin byte bits 15-8 reads fixed 01h for INTA.
// RQ7: interrupt line byte bits 7-0 read/write, resets zero; firmware fills it.
// RQ8: driver storage byte at 40h bits 15-8, reset zero, survives soft reset.
// RQ9: reserved bits ignore writes and read as zero.
package pch_pkg;
  localparam logic [7:0]  OFF_ROM_BASE  = 8'h30;
  localparam logic [7:0]  OFF_CAP_PTR   = 8'h34;
  localparam logic [7:0]  OFF_INT_CFG   = 8'h3c;
  localparam logic [7:0]  OFF_DRV_SCR   = 8'h40;
  localparam int          ROM_BASE_LSB  = 17;
  localparam logic [7:0]  CAP_PTR_VAL   = 8'hc0;
  localparam logic [7:0]  INT_PIN_VAL   = 8'h01;
  localparam logic [14:0] ROM_BASE_RST  = 15'h0000;
  localparam logic [7:0]  INT_LINE_RST  = 8'h00;
  localparam logic [7:0]  DRV_BYTE_RST  = 8'h00;
  localparam int          LAT_UNIT_NS   = 250;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          LAT_UNIT_CYC  = LAT_UNIT_NS / CLK_PERIOD_NS;
endpackage

// >>> logic/pch_sync3.sv
// three-stage synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none
module pch_sync3 (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // level in and filtered level out
  input  wire logic din,
  output logic      dout
);
  logic [2:0] sr_reg;
  logic [2:0] sr_next;
  logic       out_reg;
  logic       out_next;

  // stage 0 feeds only stage 1; stages 1 and 2 must agree before a change
  always_comb begin
    sr_next  = {sr_reg[1:0], din};
    out_next = (sr_reg[1] == sr_reg[2]) ? sr_reg[2] : out_reg;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sr_reg  <= 3'h0;
      out_reg <= 1'b0;
    end else begin
      sr_reg  <= sr_next;
      out_reg <= out_next;
    end
  end

  assign dout = out_reg;
endmodule
`default_nettype wire

// >>> logic/pch_eeload.sv
// captures eeprom-supplied latency and grant bytes when the loader is done
`timescale 1ns/1ps
`default_nettype none
module pch_eeload (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // loader side
  input  wire logic       ee_load,
  input  wire logic [7:0] ee_max_lat,
  input  wire logic [7:0] ee_min_gnt,
  // captured values
  output logic [7:0]      max_lat,
  output logic [7:0]      min_gnt
);
  logic [7:0] lat_reg;
  logic [7:0] lat_next;
  logic [7:0] gnt_reg;
  logic [7:0] gnt_next;

  // values are caught on a clocked load strobe, never through the reset
  always_comb begin
    lat_next = lat_reg;
    gnt_next = gnt_reg;
    if (ee_load) begin
      lat_next = ee_max_lat; // RQ4
      gnt_next = ee_min_gnt; // RQ5
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lat_reg <= 8'h00;
      gnt_reg <= 8'h00;
    end else begin
      lat_reg <= lat_next;
      gnt_reg <= gnt_next;
    end
  end

  assign max_lat = lat_reg;
  assign min_gnt = gnt_reg;
endmodule
`default_nettype wire

// >>> logic/pch_cfg_tail.sv
// configuration header tail registers behind an apb slave
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pch_cfg_tail (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // neighbouring header state and loader
  input  wire logic        mem_space_en,
  input  wire logic        soft_reset,
  input  wire logic        ee_load,
  input  wire logic [7:0]  ee_max_lat,
  input  wire logic [7:0]  ee_min_gnt,
  // rom decode
  input  wire logic [31:0] rom_addr,
  output logic             rom_hit,
  output logic [31:0]      rom_window_base,
  output logic             rom_access_enable,
  // values for neighbours
  output logic [7:0]       interrupt_line,
  output logic [7:0]       driver_storage_byte
);
  typedef enum logic [1:0] {
    PCH_IDLE   = 2'b01,
    PCH_ACCESS = 2'b10
  } pch_state_t;

  pch_state_t  st_reg;
  pch_state_t  st_next;
  logic [14:0] base_reg;
  logic [14:0] base_next;
  logic        en_reg;
  logic        en_next;
  logic [7:0]  line_reg;
  logic [7:0]  line_next;
  logic [7:0]  drv_reg;
  logic [7:0]  drv_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        ready_reg;
  logic        ready_next;
  logic        err_reg;
  logic        err_next;
  logic        hit_reg;
  logic        hit_next;
  logic        mem_en_s;
  logic [7:0]  max_latency_field;
  logic [7:0]  min_grant_field;

  // the command bit lives in another clock-free register block but may be
  // driven from outside this domain, so it is treated as a pin
  pch_sync3 u_mem_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (mem_space_en),
    .dout    (mem_en_s)
  );

  pch_eeload u_ee (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .ee_load    (ee_load),
    .ee_max_lat (ee_max_lat),
    .ee_min_gnt (ee_min_gnt),
    .max_lat    (max_latency_field),
    .min_gnt    (min_grant_field)
  );

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == pch_pkg::OFF_ROM_BASE) || (a == pch_pkg::OFF_CAP_PTR) ||
                 (a == pch_pkg::OFF_INT_CFG) || (a == pch_pkg::OFF_DRV_SCR);
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] a);
    case (a)
      pch_pkg::OFF_ROM_BASE:
        read_word = {base_reg, 7'h00, 9'h000, en_reg}; // RQ1 RQ9
      pch_pkg::OFF_CAP_PTR:
        read_word = {24'h000000, pch_pkg::CAP_PTR_VAL}; // RQ3
      pch_pkg::OFF_INT_CFG:
        read_word = {max_latency_field, min_grant_field, // RQ4 RQ5
                     pch_pkg::INT_PIN_VAL, line_reg}; // RQ6 RQ7
      pch_pkg::OFF_DRV_SCR:
        read_word = {16'h0000, drv_reg, 8'h00}; // RQ8 RQ9
      default:
        read_word = 32'h00000000;
    endcase
  endfunction

  // one wait state: setup, access with pready low, then pready high
  always_comb begin
    st_next    = st_reg;
    base_next  = base_reg;
    en_next    = en_reg;
    line_next  = line_reg;
    drv_next   = drv_reg;
    rdata_next = rdata_reg;
    ready_next = 1'b0;
    err_next   = 1'b0;
    case (st_reg)
      PCH_IDLE: begin
        if (psel && !penable) begin
          st_next = PCH_ACCESS;
        end
      end
      PCH_ACCESS: begin
        if (ready_reg) begin
          st_next = PCH_IDLE;
        end else if (psel && penable) begin
          ready_next = 1'b1;
          err_next   = !known_addr(paddr);
          rdata_next = pwrite ? 32'h00000000 : read_word(paddr);
          if (pwrite) begin
            case (paddr)
              pch_pkg::OFF_ROM_BASE: begin
                if (pstrb[3]) begin
                  base_next[14:7] = pwdata[31:24]; // RQ1
                end
                if (pstrb[2]) begin
                  base_next[6:0] = pwdata[23:17]; // RQ1
                end
                if (pstrb[0]) begin
                  en_next = pwdata[0]; // RQ2
                end
              end
              pch_pkg::OFF_INT_CFG: begin
                if (pstrb[0]) begin
                  line_next = pwdata[7:0]; // RQ7
                end
              end
              pch_pkg::OFF_DRV_SCR: begin
                if (pstrb[1]) begin
                  drv_next = pwdata[15:8]; // RQ8
                end
              end
              default: begin
              end
            endcase
          end
        end else begin
          st_next = PCH_IDLE;
        end
      end
      default: st_next = PCH_IDLE;
    endcase
  end

  // decode is registered, so rom_hit trails rom_addr by one cycle
  always_comb begin
    hit_next = en_reg && mem_en_s && // RQ2
               (rom_addr[31:pch_pkg::ROM_BASE_LSB] == base_reg); // RQ1
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg    <= PCH_IDLE;
      base_reg  <= pch_pkg::ROM_BASE_RST;
      en_reg    <= 1'b0;
      line_reg  <= pch_pkg::INT_LINE_RST;
      drv_reg   <= pch_pkg::DRV_BYTE_RST;
      rdata_reg <= 32'h00000000;
      ready_reg <= 1'b0;
      err_reg   <= 1'b0;
      hit_reg   <= 1'b0;
    end else begin
      st_reg    <= st_next;
      base_reg  <= base_next;
      en_reg    <= en_next;
      line_reg  <= line_next;
      drv_reg   <= drv_next;
      rdata_reg <= rdata_next;
      ready_reg <= ready_next;
      err_reg   <= err_next;
      hit_reg   <= hit_next;
    end
  end

  // soft_reset is an accepted input only; nothing here clears on it
  assign prdata              = rdata_reg;
  assign pready              = ready_reg;
  assign pslverr             = err_reg;
  assign rom_hit             = hit_reg;
  assign rom_window_base     = {base_reg, 17'h00000};
  assign rom_access_enable   = en_reg;
  assign interrupt_line      = line_reg;
  assign driver_storage_byte = drv_reg;

  chk_rom_gate: assert property (@(posedge clk_sys) disable iff (rst) // RQ2
    rom_hit |-> $past(en_reg) && $past(mem_en_s))
    else $error("rom hit without both enables");

  chk_rom_low_zero: assert property ( // RQ1
    @(posedge clk_sys) disable iff (rst)
    pready && $past(paddr) == pch_pkg::OFF_ROM_BASE && !$past(pwrite)
      |-> prdata[16:1] == 16'h0000)
    else $error("rom base low bits not zero");

  chk_cap_value: assert property (@(posedge clk_sys) disable iff (rst) // RQ3
    pready && $past(paddr) == pch_pkg::OFF_CAP_PTR && !$past(pwrite)
      |-> prdata == 32'h000000c0)
    else $error("capability pointer wrong");

  chk_lat_field: assert property (@(posedge clk_sys) disable iff (rst) // RQ4
    pready && $past(paddr) == pch_pkg::OFF_INT_CFG && !$past(pwrite)
      |-> prdata[31:24] == $past(max_latency_field))
    else $error("max latency mismatch");

  chk_gnt_field: assert property (@(posedge clk_sys) disable iff (rst) // RQ5
    pready && $past(paddr) == pch_pkg::OFF_INT_CFG && !$past(pwrite)
      |-> prdata[23:16] == $past(min_grant_field))
    else $error("min grant mismatch");

  chk_int_pin: assert property (@(posedge clk_sys) disable iff (rst) // RQ6
    pready && $past(paddr) == pch_pkg::OFF_INT_CFG && !$past(pwrite)
      |-> prdata[15:8] == 8'h01)
    else $error("interrupt pin wrong");

  chk_line_write: assert property (@(posedge clk_sys) disable iff (rst) // RQ7
    psel && penable && pwrite && !pready && paddr == pch_pkg::OFF_INT_CFG
      && pstrb[0] |=> interrupt_line == $past(pwdata[7:0]))
    else $error("interrupt line not stored");

  chk_drv_keep: assert property (@(posedge clk_sys) disable iff (rst) // RQ8
    !(psel && penable && pwrite) ##1 soft_reset |-> $stable(drv_reg))
    else $error("driver byte changed without write");

  chk_drv_resv: assert property (@(posedge clk_sys) disable iff (rst) // RQ9
    pready && $past(paddr) == pch_pkg::OFF_DRV_SCR && !$past(pwrite)
      |-> prdata[31:16] == 16'h0000 && prdata[7:0] == 8'h00)
    else $error("reserved bits not zero");

  // write checks look at the access edge, while pready is still low;
  // hold checks cover every edge on which no write is presented
  chk_err_pulse: assert property ( // RQ9
    @(posedge clk_sys) disable iff (rst)
    pslverr |-> pready)
    else $error("error flag outside a reply");

  chk_err_unmapped: assert property ( // RQ9
    @(posedge clk_sys) disable iff (rst)
    pready && !known_addr($past(paddr)) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");

  chk_write_quiet: assert property ( // RQ9
    @(posedge clk_sys) disable iff (rst)
    pready && $past(pwrite) |-> prdata == 32'h0)
    else $error("write reply carries data");

  chk_lat_load: assert property ( // RQ4
    @(posedge clk_sys) disable iff (rst)
    ee_load |=> max_latency_field == $past(ee_max_lat))
    else $error("max latency not loaded");

  chk_gnt_load: assert property ( // RQ5
    @(posedge clk_sys) disable iff (rst)
    ee_load |=> min_grant_field == $past(ee_min_gnt))
    else $error("min grant not loaded");

  chk_ee_hold: assert property ( // RQ4 RQ5
    @(posedge clk_sys) disable iff (rst)
    !ee_load |=> $stable(max_latency_field) && $stable(min_grant_field))
    else $error("eeprom bytes changed without load");

  chk_line_hold: assert property ( // RQ7
    @(posedge clk_sys) disable iff (rst)
    !(psel && penable && pwrite) |=> $stable(interrupt_line))
    else $error("interrupt line changed without write");

  chk_drv_write: assert property ( // RQ8
    @(posedge clk_sys) disable iff (rst)
    psel && penable && pwrite && !pready && paddr == pch_pkg::OFF_DRV_SCR
      && pstrb[1] |=> driver_storage_byte == $past(pwdata[15:8]))
    else $error("driver byte not stored");

  chk_drv_hold: assert property ( // RQ8
    @(posedge clk_sys) disable iff (rst)
    !(psel && penable && pwrite) |=> $stable(driver_storage_byte))
    else $error("driver byte moved with no write");

  chk_en_write: assert property ( // RQ2
    @(posedge clk_sys) disable iff (rst)
    psel && penable && pwrite && !pready && paddr == pch_pkg::OFF_ROM_BASE
      && pstrb[0] |=> rom_access_enable == $past(pwdata[0]))
    else $error("rom enable not stored");

  chk_base_write: assert property ( // RQ1
    @(posedge clk_sys) disable iff (rst)
    psel && penable && pwrite && !pready && paddr == pch_pkg::OFF_ROM_BASE
      && pstrb[3] |=> rom_window_base[31:24] == $past(pwdata[31:24]))
    else $error("rom base upper byte not stored");

  chk_base_hold: assert property ( // RQ1 RQ2
    @(posedge clk_sys) disable iff (rst)
    !(psel && penable && pwrite)
      |=> $stable(rom_window_base) && $stable(rom_access_enable))
    else $error("rom window changed without write");

  chk_rom_match: assert property ( // RQ1
    @(posedge clk_sys) disable iff (rst)
    rom_hit |-> $past(rom_addr[31:17]) == $past(rom_window_base[31:17]))
    else $error("rom hit outside the window");
endmodule
`default_nettype wire

// >>> testbench/pch_nbr_model.sv
// neighbour model: eeprom loader strobe and command register memory enable
`timescale 1ns/1ps
`default_nettype none
module pch_nbr_model #(
  parameter logic [7:0] LAT = 8'h11,
  parameter logic [7:0] GNT = 8'h22
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // memory space enable as software sets it
  input  wire logic       mem_req,
  // towards the block
  output logic            mem_space_en,
  output logic            ee_load,
  output logic [7:0]      ee_max_lat,
  output logic [7:0]      ee_min_gnt
);
  logic done_reg;
  // one load strobe after each hardware reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      done_reg <= 1'b0;
      ee_load  <= 1'b0;
    end else begin
      done_reg <= 1'b1;
      ee_load  <= !done_reg;
    end
  end
  // bytes are junk outside the strobe, so a late capture shows up
  assign ee_max_lat   = ee_load ? LAT : ~LAT;
  assign ee_min_gnt   = ee_load ? GNT : ~GNT;
  assign mem_space_en = mem_req;
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the configuration header tail
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [7:0] LAT = 8'h5a;
  localparam logic [7:0] GNT = 8'h3c;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
  logic        mem_req, soft_reset, ee_load, mem_space_en, rom_hit;
  logic        rom_access_enable;
  logic [7:0]  paddr, ee_max_lat, ee_min_gnt, interrupt_line;
  logic [7:0]  driver_storage_byte;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rom_addr, rom_window_base, seed, d;
  logic [32:0] exp_q[$];
  int          miscompares = 0;
  int          checks = 0;

  pch_cfg_tail dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_space_en(mem_space_en), .soft_reset(soft_reset),
    .ee_load(ee_load), .ee_max_lat(ee_max_lat), .ee_min_gnt(ee_min_gnt),
    .rom_addr(rom_addr), .rom_hit(rom_hit),
    .rom_window_base(rom_window_base),
    .rom_access_enable(rom_access_enable),
    .interrupt_line(interrupt_line),
    .driver_storage_byte(driver_storage_byte));

  pch_nbr_model #(.LAT(LAT), .GNT(GNT)) u_nbr (.clk_sys(clk_sys),
    .rst(rst), .mem_req(mem_req), .mem_space_en(mem_space_en),
    .ee_load(ee_load), .ee_max_lat(ee_max_lat), .ee_min_gnt(ee_min_gnt));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic print_verdict();
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [32:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // every reply is matched against the oldest note, pslverr on top
  always @(posedge clk_sys) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("stray pready", 33'h1, 33'h0);
      end else begin
        check("apb reply", {pslverr, prdata}, exp_q.pop_front());
      end
    end
  end

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] v, input logic [3:0] s,
                      input logic [32:0] e);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= v;
    pstrb   <= s;
    exp_q.push_back(e);
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) begin
      miscompares++;
      print_verdict();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    mem_req = 1'b0;
    soft_reset = 1'b0;
    rom_addr = 32'h0;
    seed = 32'd66916;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    xfer(0, 8'h30, 0, 4'hf, 33'h0);
    xfer(0, 8'h34, 0, 4'hf, 33'hc0);
    xfer(0, 8'h3c, 0, 4'hf, {1'b0, LAT, GNT, 16'h0100});
    xfer(0, 8'h40, 0, 4'hf, 33'h0);
    xfer(1, 8'h34, 32'hffffffff, 4'hf, 33'h0);
    xfer(0, 8'h34, 0, 4'hf, 33'hc0);
    xfer(0, 8'h44, 0, 4'hf, {1'b1, 32'h0});
    d = xs();
    // firmware fills the routing byte; the rest of the word is read-only
    xfer(1, 8'h3c, d, 4'hf, 33'h0);
    xfer(0, 8'h3c, 0, 4'hf, {1'b0, LAT, GNT, 8'h01, d[7:0]});
    check("int line", 33'(interrupt_line), 33'(d[7:0]));
    d = xs();
    xfer(1, 8'h40, d, 4'hf, 33'h0);
    // hold soft reset past the idle edge so the keep check really arms
    soft_reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    soft_reset <= 1'b0;
    check("drv byte", 33'(driver_storage_byte), 33'(d[15:8]));
    xfer(0, 8'h40, 0, 4'hf, {17'h0, d[15:8], 8'h0});
    d = xs() | 32'h1;
    xfer(1, 8'h30, d, 4'hf, 33'h0);
    xfer(0, 8'h30, 0, 4'hf, {1'b0, d[31:17], 17'h1});
    check("rom en", 33'(rom_access_enable), 33'h1);
    rom_addr <= {d[31:17], 17'h1abcd};
    mem_req <= 1'b1;
    // the enable pin passes a synchroniser before it counts
    repeat (8) @(posedge clk_sys);
    check("rom hit", 33'(rom_hit), 33'h1);
    check("rom base", 33'(rom_window_base), {1'b0, d[31:17], 17'h0});
    rom_addr <= ~rom_addr;
    repeat (2) @(posedge clk_sys);
    check("rom miss", 33'(rom_hit), 33'h0);
    rom_addr <= {d[31:17], 17'h0};
    mem_req <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check("rom mem off", 33'(rom_hit), 33'h0);
    mem_req <= 1'b1;
    xfer(1, 8'h30, 32'h0, 4'h1, 33'h0);
    repeat (8) @(posedge clk_sys);
    check("rom en off", 33'(rom_hit), 33'h0);
    check("en cleared", 33'(rom_access_enable), 33'h0);
    check("base kept", 33'(rom_window_base), {1'b0, d[31:17], 17'h0});
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    xfer(0, 8'h40, 0, 4'hf, 33'h0);
    xfer(0, 8'h3c, 0, 4'hf, {1'b0, LAT, GNT, 16'h0100});
    xfer(0, 8'h30, 0, 4'hf, 33'h0);
    check("line rst", 33'(interrupt_line), 33'h0);
    check("drv rst", 33'(driver_storage_byte), 33'h0);
    check("en rst", 33'(rom_access_enable), 33'h0);
    check("base rst", 33'(rom_window_base), 33'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
